// ### hdl/torque_ctrl_pkg.sv
package torque_ctrl_pkg;
	localparam logic [7:0] OFF_CFG = 8'h00;
	localparam logic [7:0] OFF_ACCEL = 8'h04;
	localparam logic [7:0] OFF_DECEL = 8'h08;
	localparam logic [7:0] OFF_SPD_LIM = 8'h0c;
	localparam logic [7:0] OFF_TRQ_CMD = 8'h10;
	localparam logic [7:0] OFF_TRQ_LIM = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
	localparam logic [7:0] OFF_NOTCH = 8'h24;

	localparam int CFG_NF_LSB = 0;
	localparam int CFG_ND_LSB = 8;
	localparam int CFG_PF_LSB = 16;
	localparam int CFG_PAT_LSB = 20;
	localparam int CFG_CAR_LSB = 24;

	localparam logic [15:0] ACCEL_RST = 16'h0064;
	localparam logic [15:0] DECEL_RST = 16'h0064;
	localparam logic [15:0] SPD_LIM_RST = 16'h0000;
	localparam logic [15:0] TRQ_LIM_RST = 16'h1000;

	localparam int IRQ_SPD = 0;
	localparam int IRQ_OC = 1;
	localparam int IRQ_OPP = 2;
	localparam int IRQ_W = 3;

	localparam int CLK_PERIOD_NS = 20;
	localparam int CTRL_PERIOD_NS = 1000;
	localparam int CTRL_DIV = CTRL_PERIOD_NS / CLK_PERIOD_NS;
	localparam int KP_SHIFT = 2;

	localparam int NOTCH_MAX = 60;
	localparam int NOTCH_BASE_DHZ = 10000;
	localparam logic [7:0] GAIN_DEPTH0 = 8'hd8;
	localparam logic [7:0] GAIN_DEPTH1 = 8'hf2;
	localparam logic [7:0] GAIN_DEPTH2 = 8'hf8;
	localparam logic [7:0] GAIN_DEPTH3 = 8'hfc;

	localparam logic [3:0] CARRIER_KHZ0 = 4'h2;
	localparam logic [3:0] CARRIER_KHZ1 = 4'h6;
	localparam logic [3:0] CARRIER_KHZ2 = 4'ha;
	localparam logic [3:0] CARRIER_KHZ3 = 4'he;

	localparam logic [3:0] PF_UV1 = 4'hb;
	localparam logic [3:0] PF_UV2 = 4'hc;
	localparam logic [3:0] PF_PLAIN1 = 4'h1;
	localparam logic [3:0] PF_PLAIN2 = 4'h2;

	typedef enum {ST_IDLE, ST_TORQUE, ST_SPEED, ST_TRIP} ctrl_state_t;

	typedef struct packed {
		logic enable;
		logic [13:0] freq_dhz;
		logic signed [7:0] gain_db;
	} notch_t;

	typedef struct packed {
		logic signed [16:0] torque;
		logic torque_fwd;
		logic speed_ctrl;
		logic overcurrent_trip;
		logic opp_rot_fault;
		logic uv_avoid_en;
		logic [3:0] pf_stop_eff;
		logic [3:0] carrier_khz;
	} drive_t;
endpackage

// ### hdl/notch_decode.sv
`timescale 1ns/1ps
module notch_decode (
	input wire logic [5:0] freq_sel,
	input wire logic [1:0] depth_sel,
	output torque_ctrl_pkg::notch_t notch
);
	logic [13:0] rom [0:63];

	// Centre frequency in 0.1 Hz units is the base divided by the selector, rounded.
	for (genvar i = 0; i < 64; i++)
	begin : g_rom
		if (i == 0 || i > torque_ctrl_pkg::NOTCH_MAX)
		begin : g_off
			assign rom[i] = 14'h0000;
		end
		else
		begin : g_on
			localparam int F = (torque_ctrl_pkg::NOTCH_BASE_DHZ + i / 2) / i;
			assign rom[i] = 14'(F);
		end
	end

	always_comb
	begin
		notch.enable = (freq_sel != 6'h00) && (int'(freq_sel) <= torque_ctrl_pkg::NOTCH_MAX);
		notch.freq_dhz = rom[freq_sel];
		case (depth_sel)
			2'h0: notch.gain_db = torque_ctrl_pkg::GAIN_DEPTH0;
			2'h1: notch.gain_db = torque_ctrl_pkg::GAIN_DEPTH1;
			2'h2: notch.gain_db = torque_ctrl_pkg::GAIN_DEPTH2;
			default: notch.gain_db = torque_ctrl_pkg::GAIN_DEPTH3;
		endcase
	end
endmodule // notch_decode

// ### hdl/torque_mode_speed_limit_ctrl.sv
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Notch selector 0 off, 1..60 falling frequency
// [RULE2] Depth 3..0 gives -4,-8,-14,-40 dB
// [RULE3] Below speed limit run torque control
// [RULE4] At or above limit switch to speed
// [RULE5] Unset speed limit means zero limit
// [RULE6] Forward start ramps limit up by accel
// [RULE7] Start removed ramps limit down by decel
// [RULE8] Zero ramp time: stop forces speed control
// [RULE9] Direction from command sign and start
// [RULE10] Speed control clamps at torque limit
// [RULE11] No undervoltage avoidance; 11/12 act 1/2 (code: torque state only; in other states 11/12 enable avoidance)
// [RULE12] Start swap in torque mode trips
// [RULE13] Software should choose linear ramp pattern
// [RULE14] Carrier only 2, 6, 10, 14 kHz
// [RULE15] Compare speed and limit each tick
module torque_mode_speed_limit_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic forward_start_cmd,
	input wire logic reverse_start_cmd,
	input wire logic [15:0] speed_meas,
	output torque_ctrl_pkg::drive_t drive,
	output torque_ctrl_pkg::notch_t notch,
	output logic irq
);
	logic [31:0] cfg_reg, cfg_next;
	logic [15:0] accel_reg, accel_next, decel_reg, decel_next;
	logic [15:0] spd_lim_reg, spd_lim_next, trq_lim_reg, trq_lim_next;
	logic signed [15:0] trq_cmd_reg, trq_cmd_next;
	logic [2:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
	logic [31:0] prdata_reg, prdata_next;
	logic [1:0] sync1_reg, sync2_reg, prev_reg;
	logic [5:0] div_reg, div_next;
	logic [15:0] limit_reg, limit_next, rcnt_reg, rcnt_next;
	logic force_reg, force_next;
	torque_ctrl_pkg::ctrl_state_t state_reg, state_next;
	torque_ctrl_pkg::drive_t drive_reg, drive_next;
	torque_ctrl_pkg::notch_t notch_reg, notch_dec;
	logic wr, rd_setup, hit, tick, run, fwd, rev, swap, oc_evt, opp_evt, spd_evt, at_limit;
	logic [15:0] target, rtime;
	logic [2:0] events;
	logic signed [16:0] mag, err, clamp_hi;
	logic signed [18:0] pterm;
	logic [3:0] pf_sel;

	assign wr = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = prdata_reg;
	assign drive = drive_reg;
	assign notch = notch_reg;
	assign irq = |(irq_stat_reg & irq_mask_reg);
	assign fwd = sync2_reg[0];
	assign rev = sync2_reg[1];
	assign run = fwd || rev;
	assign pf_sel = cfg_reg[torque_ctrl_pkg::CFG_PF_LSB +: 4];

	notch_decode u_notch (
		.freq_sel(cfg_reg[torque_ctrl_pkg::CFG_NF_LSB +: 6]),
		.depth_sel(cfg_reg[torque_ctrl_pkg::CFG_ND_LSB +: 2]),
		.notch(notch_dec)
	);

	always_comb
	begin
		case (paddr)
			torque_ctrl_pkg::OFF_CFG, torque_ctrl_pkg::OFF_ACCEL, torque_ctrl_pkg::OFF_DECEL,
			torque_ctrl_pkg::OFF_SPD_LIM, torque_ctrl_pkg::OFF_TRQ_CMD, torque_ctrl_pkg::OFF_TRQ_LIM,
			torque_ctrl_pkg::OFF_STATUS, torque_ctrl_pkg::OFF_IRQ_STAT, torque_ctrl_pkg::OFF_IRQ_MASK,
			torque_ctrl_pkg::OFF_NOTCH: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// Register file; hardware events win over a write-one-to-clear in the same cycle.
	always_comb
	begin
		cfg_next = cfg_reg;
		accel_next = accel_reg;
		decel_next = decel_reg;
		spd_lim_next = spd_lim_reg;
		trq_cmd_next = trq_cmd_reg;
		trq_lim_next = trq_lim_reg;
		irq_mask_next = irq_mask_reg;
		irq_stat_next = irq_stat_reg;
		prdata_next = prdata_reg;
		if (wr)
		begin
			case (paddr)
				torque_ctrl_pkg::OFF_CFG: cfg_next = pwdata & 32'h033f_033f;
				torque_ctrl_pkg::OFF_ACCEL: accel_next = pwdata[15:0];
				torque_ctrl_pkg::OFF_DECEL: decel_next = pwdata[15:0];
				torque_ctrl_pkg::OFF_SPD_LIM: spd_lim_next = pwdata[15:0];
				torque_ctrl_pkg::OFF_TRQ_CMD: trq_cmd_next = pwdata[15:0];
				torque_ctrl_pkg::OFF_TRQ_LIM: trq_lim_next = {1'b0, pwdata[14:0]};
				torque_ctrl_pkg::OFF_IRQ_STAT: irq_stat_next = irq_stat_reg & ~pwdata[2:0];
				torque_ctrl_pkg::OFF_IRQ_MASK: irq_mask_next = pwdata[2:0];
				default: ;
			endcase
		end
		irq_stat_next = irq_stat_next | events;
		if (rd_setup)
		begin
			case (paddr)
				torque_ctrl_pkg::OFF_CFG: prdata_next = cfg_reg;
				torque_ctrl_pkg::OFF_ACCEL: prdata_next = {16'h0000, accel_reg};
				torque_ctrl_pkg::OFF_DECEL: prdata_next = {16'h0000, decel_reg};
				torque_ctrl_pkg::OFF_SPD_LIM: prdata_next = {16'h0000, spd_lim_reg};
				torque_ctrl_pkg::OFF_TRQ_CMD: prdata_next = {16'h0000, trq_cmd_reg};
				torque_ctrl_pkg::OFF_TRQ_LIM: prdata_next = {16'h0000, trq_lim_reg};
				torque_ctrl_pkg::OFF_STATUS: prdata_next = {limit_reg, 11'h000, force_reg,
					drive_reg.torque_fwd, state_reg == torque_ctrl_pkg::ST_TRIP,
					state_reg == torque_ctrl_pkg::ST_SPEED, state_reg == torque_ctrl_pkg::ST_TORQUE};
				torque_ctrl_pkg::OFF_IRQ_STAT: prdata_next = {29'h0000_0000, irq_stat_reg};
				torque_ctrl_pkg::OFF_IRQ_MASK: prdata_next = {29'h0000_0000, irq_mask_reg};
				torque_ctrl_pkg::OFF_NOTCH: prdata_next = {8'h00, notch_reg.gain_db, 1'b0,
					notch_reg.enable, notch_reg.freq_dhz};
				default: prdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_reg <= 32'h0000_0000;
			accel_reg <= torque_ctrl_pkg::ACCEL_RST;
			decel_reg <= torque_ctrl_pkg::DECEL_RST;
			spd_lim_reg <= torque_ctrl_pkg::SPD_LIM_RST; // [RULE5]
			trq_cmd_reg <= 16'h0000;
			trq_lim_reg <= torque_ctrl_pkg::TRQ_LIM_RST;
			irq_stat_reg <= 3'h0;
			irq_mask_reg <= 3'h0;
			prdata_reg <= 32'h0000_0000;
			notch_reg <= '0;
		end
		else
		begin
			cfg_reg <= cfg_next;
			accel_reg <= accel_next;
			decel_reg <= decel_next;
			spd_lim_reg <= spd_lim_next;
			trq_cmd_reg <= trq_cmd_next;
			trq_lim_reg <= trq_lim_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			prdata_reg <= prdata_next;
			notch_reg <= notch_dec; // [RULE1] [RULE2]
		end
	end

	// Start pins are asynchronous to pclk, so they are synchronised before use.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
			prev_reg <= 2'h0;
		end
		else
		begin
			sync1_reg <= {reverse_start_cmd, forward_start_cmd};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	assign tick = (div_reg == 6'(torque_ctrl_pkg::CTRL_DIV - 1));
	assign target = run ? spd_lim_reg : 16'h0000;
	assign rtime = (limit_reg < target) ? accel_reg : decel_reg;
	assign at_limit = speed_meas >= limit_reg;
	// A direct swap is only caught while torque control owns the motor.
	assign swap = (state_reg == torque_ctrl_pkg::ST_TORQUE) && (prev_reg != sync2_reg) &&
		(prev_reg == 2'h1 || prev_reg == 2'h2) && (sync2_reg == 2'h1 || sync2_reg == 2'h2);
	assign oc_evt = swap && (speed_meas == 16'h0000); // [RULE12]
	assign opp_evt = swap && (speed_meas != 16'h0000); // [RULE12]

	always_comb
	begin
		div_next = tick ? 6'h00 : div_reg + 6'h01;
		limit_next = limit_reg;
		rcnt_next = rcnt_reg;
		force_next = force_reg;
		state_next = state_reg;
		if (tick && limit_reg != target)
		begin
			if (rtime == 16'h0000)
			begin
				limit_next = target;
				rcnt_next = 16'h0000;
			end
			else if (rcnt_reg >= rtime - 16'h0001)
			begin
				limit_next = (limit_reg < target) ? limit_reg + 16'h0001 : limit_reg - 16'h0001; // [RULE6] [RULE7]
				rcnt_next = 16'h0000;
			end
			else
			begin
				rcnt_next = rcnt_reg + 16'h0001;
			end
		end
		else if (tick)
		begin
			rcnt_next = 16'h0000;
		end
		// With a zero ramp time the limit would vanish at once, so speed control holds the stop.
		if (prev_reg != 2'h0 && !run && (accel_reg == 16'h0000 || decel_reg == 16'h0000))
		begin
			force_next = 1'b1; // [RULE8]
		end
		else if (prev_reg == 2'h0 && run)
		begin
			force_next = 1'b0;
		end
		if (oc_evt || opp_evt)
		begin
			state_next = torque_ctrl_pkg::ST_TRIP;
		end
		else
		begin
			case (state_reg)
				torque_ctrl_pkg::ST_IDLE:
					if (tick && run)
						state_next = at_limit ? torque_ctrl_pkg::ST_SPEED : torque_ctrl_pkg::ST_TORQUE; // [RULE15]
				torque_ctrl_pkg::ST_TORQUE:
					if (tick && (force_reg || at_limit))
						state_next = torque_ctrl_pkg::ST_SPEED; // [RULE4] [RULE5]
				torque_ctrl_pkg::ST_SPEED:
					if (tick && !run && limit_reg == 16'h0000 && speed_meas == 16'h0000)
						state_next = torque_ctrl_pkg::ST_IDLE;
					else if (tick && run && !force_reg && !at_limit)
						state_next = torque_ctrl_pkg::ST_TORQUE; // [RULE3] [RULE15]
				torque_ctrl_pkg::ST_TRIP:
					if (irq_stat_reg[torque_ctrl_pkg::IRQ_OPP:torque_ctrl_pkg::IRQ_OC] == 2'h0 && !run)
						state_next = torque_ctrl_pkg::ST_IDLE;
				default: state_next = torque_ctrl_pkg::ST_IDLE;
			endcase
		end
		spd_evt = (state_reg != torque_ctrl_pkg::ST_SPEED) && (state_next == torque_ctrl_pkg::ST_SPEED);
		events = 3'h0;
		events[torque_ctrl_pkg::IRQ_SPD] = spd_evt;
		events[torque_ctrl_pkg::IRQ_OC] = oc_evt;
		events[torque_ctrl_pkg::IRQ_OPP] = opp_evt;
	end

	// Drive outputs follow the present state one cycle later.
	always_comb
	begin
		mag = trq_cmd_reg[15] ? -17'(trq_cmd_reg) : 17'(trq_cmd_reg);
		err = $signed({1'b0, limit_reg}) - $signed({1'b0, speed_meas});
		pterm = 19'(err) <<< torque_ctrl_pkg::KP_SHIFT;
		clamp_hi = $signed({1'b0, trq_lim_reg});
		drive_next = '0;
		drive_next.torque_fwd = (!trq_cmd_reg[15]) == fwd; // [RULE9]
		drive_next.speed_ctrl = state_reg == torque_ctrl_pkg::ST_SPEED;
		drive_next.overcurrent_trip = irq_stat_reg[torque_ctrl_pkg::IRQ_OC];
		drive_next.opp_rot_fault = irq_stat_reg[torque_ctrl_pkg::IRQ_OPP];
		if (state_reg == torque_ctrl_pkg::ST_TORQUE)
		begin
			drive_next.torque = drive_next.torque_fwd ? mag : -mag; // [RULE3]
		end
		else if (state_reg == torque_ctrl_pkg::ST_SPEED)
		begin
			if (pterm > 19'(clamp_hi))
				drive_next.torque = clamp_hi; // [RULE10]
			else if (pterm < -19'(clamp_hi))
				drive_next.torque = -clamp_hi; // [RULE10]
			else
				drive_next.torque = 17'(pterm);
			if (rev)
				drive_next.torque = -drive_next.torque;
		end
		drive_next.uv_avoid_en = (state_reg != torque_ctrl_pkg::ST_TORQUE) &&
			(pf_sel == torque_ctrl_pkg::PF_UV1 || pf_sel == torque_ctrl_pkg::PF_UV2); // [RULE11]
		drive_next.pf_stop_eff = pf_sel;
		if (state_reg == torque_ctrl_pkg::ST_TORQUE && pf_sel == torque_ctrl_pkg::PF_UV1)
			drive_next.pf_stop_eff = torque_ctrl_pkg::PF_PLAIN1; // [RULE11]
		else if (state_reg == torque_ctrl_pkg::ST_TORQUE && pf_sel == torque_ctrl_pkg::PF_UV2)
			drive_next.pf_stop_eff = torque_ctrl_pkg::PF_PLAIN2; // [RULE11]
		case (cfg_reg[torque_ctrl_pkg::CFG_CAR_LSB +: 2])
			2'h0: drive_next.carrier_khz = torque_ctrl_pkg::CARRIER_KHZ0; // [RULE14]
			2'h1: drive_next.carrier_khz = torque_ctrl_pkg::CARRIER_KHZ1;
			2'h2: drive_next.carrier_khz = torque_ctrl_pkg::CARRIER_KHZ2;
			default: drive_next.carrier_khz = torque_ctrl_pkg::CARRIER_KHZ3;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_reg <= 6'h00;
			limit_reg <= 16'h0000;
			rcnt_reg <= 16'h0000;
			force_reg <= 1'b0;
			state_reg <= torque_ctrl_pkg::ST_IDLE;
			drive_reg <= '0;
		end
		else
		begin
			div_reg <= div_next;
			limit_reg <= limit_next;
			rcnt_reg <= rcnt_next;
			force_reg <= force_next;
			state_reg <= state_next;
			drive_reg <= drive_next;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_notch_off: assert property (cfg_reg[5:0] == 6'h00 |=> !notch.enable) // [RULE1]
		else $error("notch not disabled by zero selector");
	a_notch_top: assert property (cfg_reg[5:0] == 6'h01 |=> notch.freq_dhz == 14'h2710) // [RULE1]
		else $error("selector one is not 1000 Hz");
	a_depth_deep: assert property (cfg_reg[9:8] == 2'h0 |=> notch.gain_db == -8'sd40) // [RULE2]
		else $error("deepest depth is not -40 dB");
	a_stay_torque: assert property (tick && state_reg == torque_ctrl_pkg::ST_TORQUE && !at_limit // [RULE3]
		&& !force_reg && !swap |=> state_reg == torque_ctrl_pkg::ST_TORQUE)
		else $error("torque control left below the limit");
	a_enter_speed: assert property (tick && state_reg == torque_ctrl_pkg::ST_TORQUE && at_limit // [RULE4]
		&& !swap |=> state_reg == torque_ctrl_pkg::ST_SPEED ##1 drive.speed_ctrl)
		else $error("no speed control at the limit");
	a_zero_limit: assert property (tick && limit_reg == 16'h0000 |=> state_reg != torque_ctrl_pkg::ST_TORQUE) // [RULE5]
		else $error("torque control with zero limit");
	a_ramp_step: assert property (tick && run && accel_reg != 16'h0000 && limit_reg < target // [RULE6]
		&& rcnt_reg == accel_reg - 16'h0001 |=> limit_reg == $past(limit_reg) + 16'h0001)
		else $error("limit did not step up");
	a_ramp_down: assert property (tick && !run && decel_reg != 16'h0000 && limit_reg != 16'h0000 // [RULE7]
		&& rcnt_reg == decel_reg - 16'h0001 |=> limit_reg == $past(limit_reg) - 16'h0001)
		else $error("limit did not step down");
	a_force_speed: assert property (force_reg && tick && state_reg == torque_ctrl_pkg::ST_TORQUE // [RULE8]
		&& !swap |=> state_reg == torque_ctrl_pkg::ST_SPEED)
		else $error("forced stop not in speed control");
	a_speed_clamp: assert property (state_reg == torque_ctrl_pkg::ST_SPEED |=> // [RULE10]
		drive.torque <= $signed({1'b0, $past(trq_lim_reg)}) && drive.torque >= -$signed({1'b0, $past(trq_lim_reg)}))
		else $error("speed control torque above limit");
	a_uv_off: assert property (state_reg == torque_ctrl_pkg::ST_TORQUE |=> !drive.uv_avoid_en) // [RULE11]
		else $error("undervoltage avoidance in torque control");
	a_swap_trip: assert property (swap |=> state_reg == torque_ctrl_pkg::ST_TRIP ##1 // [RULE12]
		(drive.overcurrent_trip || drive.opp_rot_fault))
		else $error("start swap did not trip");
	a_tick_gap: assert property (tick |=> !tick [*8]) // [RULE15]
		else $error("control ticks too close");
	c_torque_run: cover property (state_reg == torque_ctrl_pkg::ST_TORQUE ##[1:200] state_reg == torque_ctrl_pkg::ST_SPEED);
	c_trip: cover property (swap);
	c_irq: cover property ($rose(irq));
endmodule // torque_mode_speed_limit_ctrl

// ### tb/motor_model.sv
`timescale 1ns/1ps
module motor_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire torque_ctrl_pkg::drive_t drive,
	input wire logic hold,
	input wire logic [15:0] hold_speed,
	output logic [15:0] speed_meas
);
	logic signed [31:0] acc_reg;
	logic signed [31:0] acc_next;

	// The shaft integrates net torque; a hold stands for a load heavy enough to pin the speed.
	always_comb
	begin
		acc_next = acc_reg + 32'($signed(drive.torque));
		if (hold)
			acc_next = {6'h00, hold_speed, 10'h000};
		else if (acc_next < 0)
			acc_next = '0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			acc_reg <= '0;
		else
			acc_reg <= acc_next;
	end

	assign speed_meas = acc_reg[25:10];
endmodule // motor_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic forward_start_cmd;
	logic reverse_start_cmd;
	logic [15:0] speed_meas;
	logic hold;
	logic [15:0] hold_speed;
	torque_ctrl_pkg::drive_t drive;
	torque_ctrl_pkg::notch_t notch;
	logic irq;
	int err_count;
	int total_checks;
	logic [31:0] rd;
	logic rd_err;
	logic [5:0] nsel [4] = '{6'h00, 6'h01, 6'h03, 6'h3c};
	logic [13:0] ndhz [4] = '{14'h0000, 14'h2710, 14'h0d05, 14'h00a7};
	logic [7:0] gains [4] = '{8'hd8, 8'hf2, 8'hf8, 8'hfc};
	logic [3:0] cars [4] = '{4'h2, 4'h6, 4'ha, 4'he};

	torque_mode_speed_limit_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.forward_start_cmd(forward_start_cmd), .reverse_start_cmd(reverse_start_cmd), .speed_meas(speed_meas),
		.drive(drive), .notch(notch), .irq(irq));

	motor_model u_motor (.pclk(pclk), .presetn(presetn), .drive(drive), .hold(hold), .hold_speed(hold_speed),
		.speed_meas(speed_meas));

	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic finish_test();
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// The request is held until pready is seen high at an edge; the wait is bounded by the watchdog.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	task automatic wait_ticks(input int n);
		repeat (n * torque_ctrl_pkg::CTRL_DIV) @(posedge pclk);
		#1;
	endtask

	task automatic pins(input logic f, input logic r);
		@(posedge pclk);
		forward_start_cmd <= f;
		reverse_start_cmd <= r;
	endtask

	initial
	begin
		repeat (30000) @(posedge pclk);
		err_count++;
		finish_test();
	end

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		forward_start_cmd = 1'b0;
		reverse_start_cmd = 1'b0;
		hold = 1'b1;
		hold_speed = 16'h0000;
		err_count = 0;
		total_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		chk(32'(drive), 32'h0);
		chk_rd(torque_ctrl_pkg::OFF_ACCEL, 32'h00000064);
		chk_rd(torque_ctrl_pkg::OFF_DECEL, 32'h00000064);
		chk_rd(torque_ctrl_pkg::OFF_SPD_LIM, 32'h0);
		chk_rd(torque_ctrl_pkg::OFF_TRQ_LIM, 32'h00001000);
		apb(1'b1, torque_ctrl_pkg::OFF_STATUS, 32'hffffffff);
		chk_rd(torque_ctrl_pkg::OFF_STATUS, 32'h0);
		apb(1'b0, 8'h30, 32'h0);
		chk({rd_err, rd}, {1'b1, 32'h0});
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, torque_ctrl_pkg::OFF_CFG, 32'(nsel[i]) | (32'(i) << 8) | (32'(i) << 24));
			wait_ticks(1);
			chk({31'h0, notch.enable}, {31'h0, i != 0});
			chk({24'h0, notch.gain_db}, {24'h0, gains[i]});
			chk({28'h0, drive.carrier_khz}, {28'h0, cars[i]});
			if (i != 0)
				chk_rd(torque_ctrl_pkg::OFF_NOTCH, {8'h00, gains[i], 2'b01, ndhz[i]});
		end
		apb(1'b1, torque_ctrl_pkg::OFF_CFG, 32'hffffffff);
		chk_rd(torque_ctrl_pkg::OFF_CFG, 32'h033f033f);
		apb(1'b1, torque_ctrl_pkg::OFF_CFG, 32'h000b0000);
		apb(1'b1, torque_ctrl_pkg::OFF_ACCEL, 32'h2);
		apb(1'b1, torque_ctrl_pkg::OFF_DECEL, 32'h2);
		apb(1'b1, torque_ctrl_pkg::OFF_SPD_LIM, 32'ha);
		apb(1'b1, torque_ctrl_pkg::OFF_TRQ_CMD, 32'h100);
		apb(1'b1, torque_ctrl_pkg::OFF_IRQ_MASK, 32'h7);
		pins(1'b1, 1'b0);
		wait_ticks(8);
		apb(1'b0, torque_ctrl_pkg::OFF_STATUS, 32'h0);
		chk({31'h0, rd[31:16] > 16'h0000 && rd[31:16] < 16'h000a}, 32'h1);
		wait_ticks(20);
		chk_rd(torque_ctrl_pkg::OFF_STATUS, 32'h000a0009);
		chk({15'h0, drive.torque}, 32'h00000100);
		chk({27'h0, drive.uv_avoid_en, drive.pf_stop_eff}, 32'h1);
		apb(1'b1, torque_ctrl_pkg::OFF_IRQ_STAT, 32'h7);
		apb(1'b1, torque_ctrl_pkg::OFF_TRQ_CMD, 32'h0000ff00);
		apb(1'b1, torque_ctrl_pkg::OFF_CFG, 32'h000c0000);
		wait_ticks(2);
		chk({26'h0, drive.torque_fwd, drive.uv_avoid_en, drive.pf_stop_eff}, 32'h2);
		hold_speed <= 16'h000c;
		wait_ticks(3);
		apb(1'b0, torque_ctrl_pkg::OFF_STATUS, 32'h0);
		chk(rd & 32'hffff0007, 32'h000a0002);
		chk({15'h0, drive.torque}, 32'h0001fff8);
		chk_rd(torque_ctrl_pkg::OFF_IRQ_STAT, 32'h1);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, torque_ctrl_pkg::OFF_TRQ_LIM, 32'h4);
		wait_ticks(2);
		chk({15'h0, drive.torque}, 32'h0001fffc);
		apb(1'b1, torque_ctrl_pkg::OFF_IRQ_MASK, 32'h0);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, torque_ctrl_pkg::OFF_IRQ_MASK, 32'h7);
		apb(1'b1, torque_ctrl_pkg::OFF_IRQ_STAT, 32'h1);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, torque_ctrl_pkg::OFF_TRQ_LIM, 32'h1000);
		// Swapping start direction in torque control is the fault the operator must avoid.
		hold_speed <= 16'h0000;
		apb(1'b1, torque_ctrl_pkg::OFF_TRQ_CMD, 32'h100);
		wait_ticks(3);
		pins(1'b0, 1'b1);
		wait_ticks(3);
		chk({31'h0, drive.overcurrent_trip}, 32'h1);
		chk_rd(torque_ctrl_pkg::OFF_IRQ_STAT, 32'h2);
		pins(1'b0, 1'b0);
		apb(1'b1, torque_ctrl_pkg::OFF_IRQ_STAT, 32'h7);
		wait_ticks(3);
		apb(1'b0, torque_ctrl_pkg::OFF_STATUS, 32'h0);
		chk(rd & 32'h00000004, 32'h0);
		apb(1'b1, torque_ctrl_pkg::OFF_TRQ_CMD, 32'h0000ff00);
		pins(1'b0, 1'b1);
		wait_ticks(25);
		chk_rd(torque_ctrl_pkg::OFF_STATUS, 32'h000a0009);
		hold_speed <= 16'h0005;
		wait_ticks(2);
		pins(1'b1, 1'b0);
		wait_ticks(3);
		chk({30'h0, drive.overcurrent_trip, drive.opp_rot_fault}, 32'h1);
		pins(1'b0, 1'b0);
		apb(1'b1, torque_ctrl_pkg::OFF_IRQ_STAT, 32'h7);
		hold_speed <= 16'h0000;
		wait_ticks(3);
		apb(1'b1, torque_ctrl_pkg::OFF_TRQ_CMD, 32'h100);
		pins(1'b1, 1'b0);
		wait_ticks(25);
		chk({15'h0, drive.torque}, 32'h00000100);
		pins(1'b0, 1'b0);
		wait_ticks(6);
		apb(1'b0, torque_ctrl_pkg::OFF_STATUS, 32'h0);
		chk({31'h0, rd[31:16] > 16'h0000 && rd[31:16] < 16'h000a}, 32'h1);
		wait_ticks(25);
		apb(1'b0, torque_ctrl_pkg::OFF_STATUS, 32'h0);
		chk(rd & 32'hffff0000, 32'h0);
		apb(1'b1, torque_ctrl_pkg::OFF_SPD_LIM, 32'h0);
		pins(1'b1, 1'b0);
		wait_ticks(3);
		chk({31'h0, drive.speed_ctrl}, 32'h1);
		pins(1'b0, 1'b0);
		wait_ticks(3);
		apb(1'b1, torque_ctrl_pkg::OFF_ACCEL, 32'h0);
		apb(1'b1, torque_ctrl_pkg::OFF_SPD_LIM, 32'ha);
		pins(1'b1, 1'b0);
		wait_ticks(3);
		apb(1'b0, torque_ctrl_pkg::OFF_STATUS, 32'h0);
		chk(rd & 32'h00000003, 32'h1);
		pins(1'b0, 1'b0);
		wait_ticks(3);
		apb(1'b0, torque_ctrl_pkg::OFF_STATUS, 32'h0);
		chk(rd & 32'h00000012, 32'h12);
		chk({31'h0, drive.speed_ctrl}, 32'h1);
		finish_test();
	end
endmodule // tb
